// ---- rtl/bsg_pkg.sv ----
// package: register map, reset values, modes and carriers of the bus-shared gpio ports
package bsg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned BSG_PORT_W = 8;
  localparam int unsigned BSG_CTL_W = 4;
  localparam int unsigned BSG_AD_W = 16;
  localparam int unsigned BSG_PADDR_W = 12;
  localparam int unsigned BSG_IDX_W = 10;
  localparam int unsigned BSG_BANK_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [BSG_IDX_W-1:0] BSG_IDX_LOW_DIR = 10'h010;
  localparam logic [BSG_IDX_W-1:0] BSG_IDX_LOW_DATA = 10'h011;
  localparam logic [BSG_IDX_W-1:0] BSG_IDX_HIGH_DIR = 10'h012;
  localparam logic [BSG_IDX_W-1:0] BSG_IDX_HIGH_DATA = 10'h013;
  localparam logic [BSG_IDX_W-1:0] BSG_IDX_CTL_DIR = 10'h014;
  localparam logic [BSG_IDX_W-1:0] BSG_IDX_CTL_DATA = 10'h015;
  localparam logic [BSG_IDX_W-1:0] BSG_IDX_BANK_SEL = 10'h020;
  localparam logic [BSG_IDX_W-1:0] BSG_IDX_MODE = 10'h021;

  // bank in which the port registers live
  localparam logic [BSG_BANK_W-1:0] BSG_PORT_BANK = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [BSG_PORT_W-1:0] BSG_DIR_RST = 8'hFF;
  localparam logic [BSG_CTL_W-1:0] BSG_CTL_DIR_RST = 4'hF;
  localparam logic [BSG_PORT_W-1:0] BSG_LATCH_RST = 8'h00;
  localparam logic [BSG_CTL_W-1:0] BSG_CTL_LATCH_RST = 4'h0;
  localparam logic [BSG_BANK_W-1:0] BSG_BANK_RST = 4'h0;

  // control port pin positions
  localparam int unsigned BSG_CTL_ALE = 0;
  localparam int unsigned BSG_CTL_OE = 1;
  localparam int unsigned BSG_CTL_WR = 2;
  localparam int unsigned BSG_CTL_CAP = 3;
  // pins of the control port that the system bus takes over
  localparam logic [BSG_CTL_W-1:0] BSG_CTL_BUS_MASK = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // operating modes from the configuration bits
  typedef enum logic [1:0] {
    BSG_MODE_MICROPROCESSOR,
    BSG_MODE_EXT_MCU,
    BSG_MODE_MCU,
    BSG_MODE_PROT_MCU
  } bsg_mode_t;

  localparam bsg_mode_t BSG_MODE_RST = BSG_MODE_MCU;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [BSG_AD_W-1:0] ad_out;
    logic ad_drive;
    logic ale;
    logic rd;
    logic wr;
  } bsg_xbus_req_t;

  typedef struct packed {
    logic [BSG_CTL_W-1:0] ctl;
    logic [BSG_PORT_W-1:0] high;
    logic [BSG_PORT_W-1:0] low;
  } bsg_pins_t;

endpackage : bsg_pkg

// ---- rtl/bsg_sync.sv ----
// two flip-flop synchroniser for pin levels
module bsg_sync #(
  parameter int unsigned W = 20
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } bsg_sync_state_t;

  bsg_sync_state_t state_q;
  bsg_sync_state_t state_d;

  always_comb begin
    state_d = state_q;
    state_d.meta = i_async;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_sync = state_q.stable;

endmodule : bsg_sync

// ---- rtl/bsg_port_pad.sv ----
// registered pin driver: gpio latch and direction, overridden bit by bit by the system bus
module bsg_port_pad #(
  parameter int unsigned W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic [W-1:0] i_latch,
  input wire logic [W-1:0] i_dir,
  input wire logic [W-1:0] i_bus_own,
  input wire logic [W-1:0] i_bus_out,
  input wire logic [W-1:0] i_bus_oe_n,
  output logic [W-1:0] o_pin_out,
  output logic [W-1:0] o_pin_oe_n
);

  typedef struct packed {
    logic [W-1:0] out;
    logic [W-1:0] oe_n;
  } bsg_pad_state_t;

  bsg_pad_state_t state_q;
  bsg_pad_state_t state_d;

  always_comb begin
    state_d = state_q;
    for (int i = 0; i < W; i++) begin
      if (i_bus_own[i]) begin
        state_d.out[i] = i_bus_out[i];
        state_d.oe_n[i] = i_bus_oe_n[i];
      end else begin
        // direction one makes the pin an input, zero drives the latch
        state_d.out[i] = i_latch[i];
        state_d.oe_n[i] = i_dir[i];
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q.out <= '0;
      state_q.oe_n <= '1;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_pin_out = state_q.out;
  assign o_pin_oe_n = state_q.oe_n;

endmodule : bsg_port_pad

// ---- rtl/bsg_ports.sv ----
// bus-shared gpio ports: apb register file, mode steering and pin drivers
//
// Functional notes
// - direction bit one makes a pin input; zero drives it from the latch
// - data register reads give pin levels; writes change only the output latch
// - in bus modes the high port carries address/data bits 15 to 8
// - bus pins go to the system bus in microprocessor or extended modes only
// - control port is four bits; three give latch-enable, output-enable, write strobes
// - output-enable and write strobes are driven active low
// - in plain microcontroller modes control pins 2 to 0 are ordinary gpio
// - every reset sets both byte-port direction registers to all ones
// - data latches survive master-clear or watchdog reset; power-on value unspecified
// - in bus modes the low port carries address/data bits 7 to 0
//
// Decided for this implementation: register access over APB.
module bsg_ports (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // master-clear or watchdog reset, one-cycle pulse in the core domain
  input wire logic i_warm_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [bsg_pkg::BSG_PADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // system bus request from the core's external memory interface
  input wire bsg_pkg::bsg_xbus_req_t i_xbus,
  output logic [bsg_pkg::BSG_AD_W-1:0] o_xbus_ad_in,
  output logic o_bus_mode,
  output logic o_fourth_capture_input,
  // pins
  input wire bsg_pkg::bsg_pins_t i_pin_in,
  output bsg_pkg::bsg_pins_t o_pin_out,
  output bsg_pkg::bsg_pins_t o_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [bsg_pkg::BSG_BANK_W-1:0] bank_select;
    bsg_pkg::bsg_mode_t mode;
    logic [bsg_pkg::BSG_PORT_W-1:0] low_byte_direction;
    logic [bsg_pkg::BSG_PORT_W-1:0] low_byte_port_data;
    logic [bsg_pkg::BSG_PORT_W-1:0] high_byte_direction;
    logic [bsg_pkg::BSG_PORT_W-1:0] high_byte_port_data;
    logic [bsg_pkg::BSG_CTL_W-1:0] control_port_direction;
    logic [bsg_pkg::BSG_CTL_W-1:0] control_port_data;
    logic bus_mode;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bsg_state_t;

  bsg_state_t state_q;
  bsg_state_t state_d;

  bsg_pkg::bsg_pins_t pins_sync;

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs pass two flip-flops before any read

  bsg_sync #(
    .W($bits(bsg_pkg::bsg_pins_t))
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async(i_pin_in),
    .o_sync(pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic setup_phase;
  logic access_done;
  logic [bsg_pkg::BSG_IDX_W-1:0] reg_idx;
  logic bank_ok;
  logic is_port_reg;
  logic is_mapped;
  logic [31:0] read_word;

  assign setup_phase = i_psel && !i_penable;
  assign access_done = i_psel && i_penable && state_q.pready;
  assign reg_idx = i_paddr[bsg_pkg::BSG_PADDR_W-1:2];
  // port registers answer only in their own bank
  assign bank_ok = (state_q.bank_select == bsg_pkg::BSG_PORT_BANK);

  always_comb begin
    is_port_reg = 1'b0;
    is_mapped = 1'b1;
    read_word = 32'h0000_0000;
    unique case (reg_idx)
      bsg_pkg::BSG_IDX_LOW_DIR: begin
        is_port_reg = 1'b1;
        read_word = {24'h00_0000, state_q.low_byte_direction};
      end
      bsg_pkg::BSG_IDX_LOW_DATA: begin
        is_port_reg = 1'b1;
        read_word = {24'h00_0000, pins_sync.low};
      end
      bsg_pkg::BSG_IDX_HIGH_DIR: begin
        is_port_reg = 1'b1;
        read_word = {24'h00_0000, state_q.high_byte_direction};
      end
      bsg_pkg::BSG_IDX_HIGH_DATA: begin
        is_port_reg = 1'b1;
        read_word = {24'h00_0000, pins_sync.high};
      end
      bsg_pkg::BSG_IDX_CTL_DIR: begin
        is_port_reg = 1'b1;
        read_word = {28'h000_0000, state_q.control_port_direction};
      end
      bsg_pkg::BSG_IDX_CTL_DATA: begin
        is_port_reg = 1'b1;
        read_word = {28'h000_0000, pins_sync.ctl};
      end
      bsg_pkg::BSG_IDX_BANK_SEL: begin
        read_word = {28'h000_0000, state_q.bank_select};
      end
      bsg_pkg::BSG_IDX_MODE: begin
        read_word = {30'h0000_0000, state_q.mode};
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
    if (is_port_reg && !bank_ok) begin
      read_word = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;
    state_d.pready = 1'b0;
    state_d.pslverr = 1'b0;

    // answer is prepared in the setup cycle, so the access phase lasts one cycle
    if (setup_phase) begin
      state_d.pready = 1'b1;
      state_d.prdata = read_word;
      state_d.pslverr = !is_mapped || (is_port_reg && !bank_ok);
    end

    // writes take effect at the edge where pready is sampled high
    if (access_done && i_pwrite && !state_q.pslverr) begin
      unique case (reg_idx)
        bsg_pkg::BSG_IDX_LOW_DIR: begin
          state_d.low_byte_direction = i_pwdata[bsg_pkg::BSG_PORT_W-1:0];
        end
        bsg_pkg::BSG_IDX_LOW_DATA: begin
          state_d.low_byte_port_data = i_pwdata[bsg_pkg::BSG_PORT_W-1:0];
        end
        bsg_pkg::BSG_IDX_HIGH_DIR: begin
          state_d.high_byte_direction = i_pwdata[bsg_pkg::BSG_PORT_W-1:0];
        end
        bsg_pkg::BSG_IDX_HIGH_DATA: begin
          state_d.high_byte_port_data = i_pwdata[bsg_pkg::BSG_PORT_W-1:0];
        end
        bsg_pkg::BSG_IDX_CTL_DIR: begin
          state_d.control_port_direction = i_pwdata[bsg_pkg::BSG_CTL_W-1:0];
        end
        bsg_pkg::BSG_IDX_CTL_DATA: begin
          state_d.control_port_data = i_pwdata[bsg_pkg::BSG_CTL_W-1:0];
        end
        bsg_pkg::BSG_IDX_BANK_SEL: begin
          state_d.bank_select = i_pwdata[bsg_pkg::BSG_BANK_W-1:0];
        end
        bsg_pkg::BSG_IDX_MODE: begin
          state_d.mode = bsg_pkg::bsg_mode_t'(i_pwdata[1:0]);
        end
        default: begin
        end
      endcase
    end

    // bus pins go to the system bus only in the two external modes
    state_d.bus_mode = (state_d.mode == bsg_pkg::BSG_MODE_MICROPROCESSOR) ||
                       (state_d.mode == bsg_pkg::BSG_MODE_EXT_MCU);

    // warm reset forces pins not owned by the system bus to input but leaves the data latches alone
    if (i_warm_reset) begin
      state_d.low_byte_direction = bsg_pkg::BSG_DIR_RST;
      state_d.high_byte_direction = bsg_pkg::BSG_DIR_RST;
      state_d.control_port_direction = bsg_pkg::BSG_CTL_DIR_RST;
      state_d.pready = 1'b0;
      state_d.pslverr = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q.bank_select <= bsg_pkg::BSG_BANK_RST;
      state_q.mode <= bsg_pkg::BSG_MODE_RST;
      state_q.low_byte_direction <= bsg_pkg::BSG_DIR_RST;
      state_q.high_byte_direction <= bsg_pkg::BSG_DIR_RST;
      state_q.control_port_direction <= bsg_pkg::BSG_CTL_DIR_RST;
      state_q.low_byte_port_data <= bsg_pkg::BSG_LATCH_RST;
      state_q.high_byte_port_data <= bsg_pkg::BSG_LATCH_RST;
      state_q.control_port_data <= bsg_pkg::BSG_CTL_LATCH_RST;
      state_q.bus_mode <= 1'b0;
      state_q.pready <= 1'b0;
      state_q.pslverr <= 1'b0;
      state_q.prdata <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system bus steering

  logic [bsg_pkg::BSG_PORT_W-1:0] ad_own;
  logic [bsg_pkg::BSG_PORT_W-1:0] ad_oe_n;
  logic [bsg_pkg::BSG_CTL_W-1:0] ctl_own;
  logic [bsg_pkg::BSG_CTL_W-1:0] ctl_bus_out;

  assign ad_own = {bsg_pkg::BSG_PORT_W{state_q.bus_mode}};
  assign ad_oe_n = {bsg_pkg::BSG_PORT_W{!i_xbus.ad_drive}};

  // in plain microcontroller modes no control pin is owned, so all stay gpio
  assign ctl_own = state_q.bus_mode ? bsg_pkg::BSG_CTL_BUS_MASK : 4'h0;

  always_comb begin
    ctl_bus_out = 4'h0;
    ctl_bus_out[bsg_pkg::BSG_CTL_ALE] = i_xbus.ale;
    ctl_bus_out[bsg_pkg::BSG_CTL_OE] = !i_xbus.rd;
    ctl_bus_out[bsg_pkg::BSG_CTL_WR] = !i_xbus.wr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  bsg_port_pad #(
    .W(bsg_pkg::BSG_PORT_W)
  ) u_low_pad (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_latch(state_q.low_byte_port_data),
    .i_dir(state_q.low_byte_direction),
    .i_bus_own(ad_own),
    .i_bus_out(i_xbus.ad_out[7:0]),
    .i_bus_oe_n(ad_oe_n),
    .o_pin_out(o_pin_out.low),
    .o_pin_oe_n(o_pin_oe_n.low)
  );

  bsg_port_pad #(
    .W(bsg_pkg::BSG_PORT_W)
  ) u_high_pad (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_latch(state_q.high_byte_port_data),
    .i_dir(state_q.high_byte_direction),
    .i_bus_own(ad_own),
    .i_bus_out(i_xbus.ad_out[15:8]),
    .i_bus_oe_n(ad_oe_n),
    .o_pin_out(o_pin_out.high),
    .o_pin_oe_n(o_pin_oe_n.high)
  );

  bsg_port_pad #(
    .W(bsg_pkg::BSG_CTL_W)
  ) u_ctl_pad (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_latch(state_q.control_port_data),
    .i_dir(state_q.control_port_direction),
    .i_bus_own(ctl_own),
    .i_bus_out(ctl_bus_out),
    .i_bus_oe_n(4'h0),
    .o_pin_out(o_pin_out.ctl),
    .o_pin_oe_n(o_pin_oe_n.ctl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_prdata = state_q.prdata;
  assign o_pready = state_q.pready;
  assign o_pslverr = state_q.pslverr;
  assign o_bus_mode = state_q.bus_mode;
  assign o_xbus_ad_in = {pins_sync.high, pins_sync.low};
  assign o_fourth_capture_input = pins_sync.ctl[bsg_pkg::BSG_CTL_CAP];

endmodule : bsg_ports

// ---- sim/bsg_ports_props.sv ----
// checker: port-level properties of the bus-shared gpio ports
module bsg_ports_props (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_warm_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire bsg_pkg::bsg_xbus_req_t i_xbus,
  input wire logic [bsg_pkg::BSG_AD_W-1:0] o_xbus_ad_in,
  input wire logic o_bus_mode,
  input wire logic o_fourth_capture_input,
  input wire bsg_pkg::bsg_pins_t i_pin_in,
  input wire bsg_pkg::bsg_pins_t o_pin_out,
  input wire bsg_pkg::bsg_pins_t o_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  // synchroniser history is only valid from the third edge after reset
  logic [1:0] up_q;
  logic [1:0] up_d;
  always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) up_q <= 2'h0;
    else up_q <= up_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (i_psel && !i_penable && !i_warm_reset |=> o_pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
    else $error("pready without setup");
  a_err_reads_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("pslverr outside answer or with data");
  a_low_ad_bus: assert property (o_bus_mode |=> o_pin_out.low == $past(i_xbus.ad_out[7:0])
    && o_pin_oe_n.low == {8{!$past(i_xbus.ad_drive)}}) else $error("low byte not bus");
  a_high_ad_bus: assert property (o_bus_mode |=> o_pin_out.high == $past(i_xbus.ad_out[15:8])
    && o_pin_oe_n.high == {8{!$past(i_xbus.ad_drive)}}) else $error("high byte not bus");
  a_strobe_levels: assert property (o_bus_mode |=> o_pin_oe_n.ctl[2:0] == 3'h0
    && o_pin_out.ctl[2:0] == {!$past(i_xbus.wr), !$past(i_xbus.rd), $past(i_xbus.ale)})
    else $error("strobe pins wrong");
  a_warm_inputs: assert property (i_warm_reset && !o_bus_mode ##1 !o_bus_mode |=>
    o_pin_oe_n.low == 8'hFF && o_pin_oe_n.high == 8'hFF) else $error("warm reset left outputs");
  a_sync_pins: assert property (up_q == 2'h3 |-> o_xbus_ad_in == $past({i_pin_in.high, i_pin_in.low}, 2)
    && o_fourth_capture_input == $past(i_pin_in.ctl[3], 2)) else $error("pin sync wrong");
endmodule : bsg_ports_props

bind bsg_ports bsg_ports_props i_props (
  .i_core_clk(i_core_clk),
  .i_resetn(i_resetn),
  .i_warm_reset(i_warm_reset),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .o_prdata(o_prdata),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .i_xbus(i_xbus),
  .o_xbus_ad_in(o_xbus_ad_in),
  .o_bus_mode(o_bus_mode),
  .o_fourth_capture_input(o_fourth_capture_input),
  .i_pin_in(i_pin_in),
  .o_pin_out(o_pin_out),
  .o_pin_oe_n(o_pin_oe_n)
);

// ---- sim/bsg_pin_model.sv ----
// partner: external loads and memory on the shared pins
module bsg_pin_model (
  input wire bsg_pkg::bsg_pins_t i_pin_out,
  input wire bsg_pkg::bsg_pins_t i_pin_oe_n,
  input wire bsg_pkg::bsg_pins_t i_ext,
  output bsg_pkg::bsg_pins_t o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin shows the outside driver, never a held copy of the last drive
  assign o_level = bsg_pkg::bsg_pins_t'((i_pin_out & ~i_pin_oe_n) | (i_ext & i_pin_oe_n));
endmodule : bsg_pin_model

// ---- sim/bsg_ports_test.sv ----
// testbench: apb-driven checks of the bus-shared gpio ports
module bsg_ports_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic resetn;
  logic warm;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bus_mode;
  logic cap;
  logic [15:0] ad_in;
  bsg_pkg::bsg_xbus_req_t xbus;
  bsg_pkg::bsg_pins_t pin_in;
  bsg_pkg::bsg_pins_t pin_out;
  bsg_pkg::bsg_pins_t pin_oe_n;
  bsg_pkg::bsg_pins_t ext;
  int err_total = 0;
  int compares = 0;

  always #5 core_clk = ~core_clk;

  bsg_ports i_dut (.i_core_clk(core_clk), .i_resetn(resetn), .i_warm_reset(warm), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_xbus(xbus), .o_xbus_ad_in(ad_in), .o_bus_mode(bus_mode),
    .o_fourth_capture_input(cap), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n));
  bsg_pin_model i_pins (.i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n), .i_ext(ext), .o_level(pin_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1);
    // no wait states: the answer stands in the first access cycle
    chk(32'(n), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, idx, d, r, e);
    chk({31'h0, e}, 32'h0);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'h0, idx, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, experr});
  endtask : rd

  task automatic settle;
    repeat (5) @(posedge core_clk);
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'h0;
    warm = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    xbus = '{ad_out: 16'hBEEF, ad_drive: 1'h1, ale: 1'h1, rd: 1'h1, wr: 1'h0};
    ext = '{ctl: 4'hA, high: 8'h3C, low: 8'hC3};
    repeat (3) @(posedge core_clk);
    resetn <= 1'h1;
    @(posedge core_clk);
    rd(bsg_pkg::BSG_IDX_LOW_DIR, 32'h0, 1'h1);
    wr(bsg_pkg::BSG_IDX_BANK_SEL, 32'h1);
    rd(bsg_pkg::BSG_IDX_LOW_DIR, 32'hFF, 1'h0);
    rd(bsg_pkg::BSG_IDX_HIGH_DIR, 32'hFF, 1'h0);
    rd(bsg_pkg::BSG_IDX_CTL_DIR, 32'hF, 1'h0);
    rd(10'h3FF, 32'h0, 1'h1);
    wr(bsg_pkg::BSG_IDX_LOW_DATA, 32'h5A);
    wr(bsg_pkg::BSG_IDX_LOW_DIR, 32'h0F);
    wr(bsg_pkg::BSG_IDX_HIGH_DATA, 32'hA5);
    wr(bsg_pkg::BSG_IDX_HIGH_DIR, 32'hF0);
    wr(bsg_pkg::BSG_IDX_CTL_DATA, 32'hF5);
    wr(bsg_pkg::BSG_IDX_CTL_DIR, 32'hF8);
    settle();
    chk({12'h0, pin_oe_n}, 32'h8F00F);
    chk({12'h0, pin_out}, 32'h5A55A);
    rd(bsg_pkg::BSG_IDX_LOW_DATA, 32'h53, 1'h0);
    rd(bsg_pkg::BSG_IDX_HIGH_DATA, 32'h35, 1'h0);
    rd(bsg_pkg::BSG_IDX_CTL_DIR, 32'h8, 1'h0);
    rd(bsg_pkg::BSG_IDX_CTL_DATA, 32'hD, 1'h0);
    warm <= 1'h1;
    @(posedge core_clk);
    warm <= 1'h0;
    settle();
    chk({12'h0, pin_oe_n}, 32'hFFFFF);
    rd(bsg_pkg::BSG_IDX_LOW_DIR, 32'hFF, 1'h0);
    wr(bsg_pkg::BSG_IDX_LOW_DIR, 32'h0);
    wr(bsg_pkg::BSG_IDX_HIGH_DIR, 32'h0);
    settle();
    chk({12'h0, pin_out}, 32'h5A55A);
    rd(bsg_pkg::BSG_IDX_LOW_DATA, 32'h5A, 1'h0);
    for (int m = 0; m < 4; m++) begin
      wr(bsg_pkg::BSG_IDX_MODE, 32'(m));
      settle();
      chk({31'h0, bus_mode}, (m < 2) ? 32'h1 : 32'h0);
      chk({12'h0, pin_out}, (m < 2) ? 32'h5BEEF : 32'h5A55A);
      chk({12'h0, pin_oe_n}, (m < 2) ? 32'h80000 : 32'hF0000);
    end
    wr(bsg_pkg::BSG_IDX_MODE, 32'h1);
    xbus <= '{ad_out: 16'h1234, ad_drive: 1'h0, ale: 1'h0, rd: 1'h0, wr: 1'h1};
    settle();
    chk({12'h0, pin_oe_n}, 32'h8FFFF);
    chk({12'h0, pin_out}, 32'h21234);
    chk({16'h0, ad_in}, 32'h3CC3);
    chk({31'h0, cap}, 32'h1);
    give_verdict();
  end

  initial begin
    #100us;
    $display("mismatch at %0t: watchdog expired", $time);
    err_total++;
    give_verdict();
  end
endmodule : bsg_ports_test
